// >>> rtl/flash_port_defines.vh
/*
 * Constants for the serial flash program port: control codes, serial
 * field lengths and the nonvolatile operation control layout.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef FLASH_PORT_DEFINES_VH
`define FLASH_PORT_DEFINES_VH

// ----------------------------------------------------------------------
// Serial control codes and field lengths
// ----------------------------------------------------------------------
`define CODE_BITS          4
`define CODE_SIX           4'h0
`define CODE_REGISTER_READOUT_CODE        4'h1
`define INSTR_BITS         24
`define READ_IDLE_CYCLES   8
`define READ_DATA_BITS     16

// ----------------------------------------------------------------------
// Operation control register layout
// ----------------------------------------------------------------------
`define CTRL_WIDTH         16
`define CTRL_RESET         16'h0000
`define BIT_START          15
`define BIT_PERMIT         14
`define BIT_SEQ_ERR        13
`define BIT_IDLE_STOP      12
`define BIT_ROW_FMT        9
`define BIT_ROW_UNDERRUN   8
`define OP_MSB             3
`define OP_LSB             0

// ----------------------------------------------------------------------
// Operation select encodings
// ----------------------------------------------------------------------
`define OP_BULK_ERASE      4'hE
`define OP_PAGE_ERASE      4'h3
`define OP_ROW_PROGRAM     4'h2
`define OP_DOUBLE_WORD     4'h1

// ----------------------------------------------------------------------
// Unlock key and register selects
// ----------------------------------------------------------------------
`define KEY_FIRST          8'h55
`define KEY_SECOND         8'hAA
`define SEL_CONTROL        1'b0
`define SEL_KEY            1'b1

// ----------------------------------------------------------------------
// Program counter safety and double-word alignment
// ----------------------------------------------------------------------
`define VECTOR_LAST        24'h0001FF
`define DW_ALIGN_MASK      24'hFFFFF8

`endif

// >>> rtl/instr_fifo.v
/*
 * Parameterised FIFO for shifted-in instructions, with a registered
 * output stage so read data always come from flip-flops.
 * Assumes one clock and the asynchronous active-low reset.
 */
`timescale 1ns/100ps

module instr_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clock_i,
    input  wire             rst_n_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    output reg  [WIDTH-1:0] out_data_o,
    output reg              out_valid_o,
    input  wire             out_ready_i
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_q;
    reg [AW-1:0]    rd_ptr_q;
    reg [AW:0]      count_q;
    wire            push;
    wire            pop;

    localparam [AW:0] FULL_LEVEL = DEPTH;

    assign in_ready_o = (count_q < FULL_LEVEL);
    assign push       = in_valid_i && in_ready_o;
    assign pop        = (count_q != {(AW+1){1'b0}}) &&
                        (!out_valid_o || out_ready_i);

    always @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data_i;
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_q    <= {AW{1'b0}};
            rd_ptr_q    <= {AW{1'b0}};
            count_q     <= {(AW+1){1'b0}};
            out_valid_o <= 1'b0;
            out_data_o  <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_q   <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
                out_data_o <= mem[rd_ptr_q];
            end
            if (pop) begin
                out_valid_o <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
            if (push && !pop) begin
                count_q <= count_q + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_q <= count_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule

// >>> rtl/serial_flash_program_port.v
/*
 * Serial flash program port: takes control codes and instructions from
 * the programming clock and data pins, hands instructions to the CPU
 * through a FIFO, shifts the visible output register out, and runs the
 * nonvolatile operation control register with its unlock key.
 * Assumes a CPU that pops instructions, writes the control and key
 * registers through the write port, and reports its program counter.
 */
`timescale 1ns/100ps

`include "flash_port_defines.vh"

module serial_flash_program_port #(
    parameter FLASH_LAST  = 24'h02ABFE,
    parameter BULK_EDGES  = 16'd64,
    parameter PAGE_EDGES  = 16'd32,
    parameter DWORD_EDGES = 16'd16,
    parameter FIFO_DEPTH  = 16
) (
    input  wire        clock_i,
    input  wire        rst_n_i,
    input  wire        prog_clock_pin_i,
    input  wire        prog_data_pin_i,
    output wire        prog_data_pin_o,
    output wire        prog_data_pin_oe_o,
    output wire [23:0] instr_data_o,
    output wire        instr_valid_o,
    input  wire        instr_ready_i,
    output reg         cpu_tick_o,
    input  wire [15:0] visi_data_i,
    input  wire        reg_wr_i,
    input  wire        reg_sel_i,
    input  wire [15:0] reg_wdata_i,
    output wire [15:0] reg_rdata_o,
    input  wire [23:0] pc_i,
    output reg         device_reset_o,
    input  wire        idle_i,
    input  wire        power_save_req_i,
    output reg         power_save_grant_o,
    input  wire [23:0] nvm_addr_i,
    output reg  [23:0] flash_addr_o,
    output wire [3:0]  flash_op_o,
    output wire        flash_busy_o,
    output reg         flash_step_o
);

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    reg [2:0] pgc_sync_q;
    reg [1:0] pgd_sync_q;
    wire      pc_rise;
    wire      pc_fall;
    wire      din;

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pgc_sync_q <= 3'h0;
            pgd_sync_q <= 2'h0;
        end else begin
            pgc_sync_q <= {pgc_sync_q[1:0], prog_clock_pin_i};
            pgd_sync_q <= {pgd_sync_q[0], prog_data_pin_i};
        end
    end

    // Edges compare the second and third stage only
    assign pc_rise = pgc_sync_q[1] && !pgc_sync_q[2];
    assign pc_fall = !pgc_sync_q[1] && pgc_sync_q[2];
    assign din     = pgd_sync_q[1];

    // ------------------------------------------------------------------
    // Serial sequencer
    // ------------------------------------------------------------------
    localparam ST_CODE  = 3'h0;
    localparam ST_SIX   = 3'h1;
    localparam ST_PUSH  = 3'h2;
    localparam ST_RIDLE = 3'h3;
    localparam ST_ROUT  = 3'h4;
    localparam ST_HOLD  = 3'h5;

    reg [2:0]  state_q;
    reg [2:0]  state_d;
    reg [4:0]  cnt_q;
    reg [4:0]  cnt_d;
    reg [3:0]  code_q;
    reg [3:0]  code_d;
    reg [23:0] instr_q;
    reg [23:0] instr_d;
    reg [15:0] shift_q;
    reg [15:0] shift_d;
    reg        dout_q;
    reg        dout_d;
    reg        oe_q;
    reg        oe_d;
    wire       fifo_in_ready;
    wire [3:0] code_full;

    assign code_full = {din, code_q[3:1]};

    always @* begin
        state_d = state_q;
        cnt_d   = cnt_q;
        code_d  = code_q;
        instr_d = instr_q;
        shift_d = shift_q;
        dout_d  = dout_q;
        oe_d    = oe_q;
        case (state_q)
            ST_CODE: begin
                if (pc_rise) begin
                    code_d = code_full;
                    cnt_d  = cnt_q + 5'h1;
                    if (cnt_q == `CODE_BITS - 1) begin
                        cnt_d = 5'h0;
                        if (code_full == `CODE_SIX) begin
                            state_d = ST_SIX;
                        end else if (code_full == `CODE_REGISTER_READOUT_CODE) begin
                            state_d = ST_RIDLE;
                        end else begin
                            state_d = ST_CODE;
                        end
                    end
                end
            end
            ST_SIX: begin
                if (pc_rise) begin
                    instr_d = {din, instr_q[23:1]};
                    cnt_d   = cnt_q + 5'h1;
                    if (cnt_q == `INSTR_BITS - 1) begin
                        cnt_d   = 5'h0;
                        state_d = ST_PUSH;
                    end
                end
            end
            ST_PUSH: begin
                // Edges arriving while the FIFO is full are lost; the
                // programmer paces itself through readout polling
                if (fifo_in_ready) begin
                    state_d = ST_CODE;
                end
            end
            ST_RIDLE: begin
                if (pc_rise) begin
                    cnt_d = cnt_q + 5'h1;
                    if (cnt_q == `READ_IDLE_CYCLES - 1) begin
                        cnt_d   = 5'h0;
                        shift_d = visi_data_i;
                        oe_d    = 1'b1;
                        state_d = ST_ROUT;
                    end
                end
            end
            ST_ROUT: begin
                if (pc_fall) begin
                    dout_d  = shift_q[0];
                    shift_d = {1'b0, shift_q[15:1]};
                end
                if (pc_rise) begin
                    cnt_d = cnt_q + 5'h1;
                    if (cnt_q == `READ_DATA_BITS - 1) begin
                        cnt_d   = 5'h0;
                        state_d = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                // The releasing edge already carries the next code's bit
                if (pc_rise) begin
                    oe_d    = 1'b0;
                    code_d  = {din, code_q[3:1]};
                    cnt_d   = 5'h1;
                    state_d = ST_CODE;
                end
            end
            default: begin
                state_d = ST_CODE;
                cnt_d   = 5'h0;
                oe_d    = 1'b0;
            end
        endcase
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q    <= ST_CODE;
            cnt_q      <= 5'h0;
            code_q     <= 4'h0;
            instr_q    <= 24'h000000;
            shift_q    <= 16'h0000;
            dout_q     <= 1'b0;
            oe_q       <= 1'b0;
            cpu_tick_o <= 1'b0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            code_q     <= code_d;
            instr_q    <= instr_d;
            shift_q    <= shift_d;
            dout_q     <= dout_d;
            oe_q       <= oe_d;
            // CPU clocks only while the next code shifts in
            cpu_tick_o <= pc_rise && (state_q == ST_CODE);
        end
    end

    assign prog_data_pin_o    = dout_q;
    assign prog_data_pin_oe_o = oe_q;

    instr_fifo #(
        .WIDTH (`INSTR_BITS),
        .DEPTH (FIFO_DEPTH),
        .AW    ($clog2(FIFO_DEPTH))
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (instr_q),
        .in_valid_i  (state_q == ST_PUSH),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (instr_data_o),
        .out_valid_o (instr_valid_o),
        .out_ready_i (instr_ready_i)
    );

    // ------------------------------------------------------------------
    // Program counter guard
    // ------------------------------------------------------------------
    wire pc_bad;

    // No stall insertion here; hazards are the feeder's job
    assign pc_bad = (pc_i <= `VECTOR_LAST) || (pc_i > FLASH_LAST);

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            device_reset_o <= 1'b0;
        end else begin
            device_reset_o <= pc_bad;
        end
    end

    // ------------------------------------------------------------------
    // Nonvolatile operation control and unlock key
    // ------------------------------------------------------------------
    function op_valid;
        input [3:0] op;
        begin
            op_valid = (op == `OP_BULK_ERASE) ||
                       (op == `OP_PAGE_ERASE) ||
                       (op == `OP_DOUBLE_WORD);
        end
    endfunction

    reg        start_q;
    reg        permit_q;
    reg        err_q;
    reg        idle_stop_q;
    reg        row_fmt_q;
    reg        underrun_q;
    reg [3:0]  op_q;
    reg [1:0]  key_q;
    reg [15:0] step_q;
    reg [15:0] op_len;
    wire       ctrl_wr;
    wire       key_wr;
    wire       start_try;
    wire       start_ok;
    wire       advance;
    wire       done;

    assign ctrl_wr   = reg_wr_i && (reg_sel_i == `SEL_CONTROL);
    assign key_wr    = reg_wr_i && (reg_sel_i == `SEL_KEY);
    assign start_try = ctrl_wr && reg_wdata_i[`BIT_START] && !start_q;
    // Row program is not offered on this port
    assign start_ok  = start_try && (key_q == 2'h2) &&
                       reg_wdata_i[`BIT_PERMIT] &&
                       op_valid(reg_wdata_i[`OP_MSB:`OP_LSB]);
    assign advance   = start_q && pc_rise &&
                       !(idle_i && idle_stop_q);
    assign done      = advance && (step_q == op_len - 16'h1);

    always @* begin
        case (op_q)
            `OP_BULK_ERASE:  op_len = BULK_EDGES;
            `OP_PAGE_ERASE:  op_len = PAGE_EDGES;
            `OP_DOUBLE_WORD: op_len = DWORD_EDGES;
            default:         op_len = DWORD_EDGES;
        endcase
    end

    // The power-on reset clears all these bits; device_reset_o also clears key_q if key_wr is low, and while start_q is set it clears start_q and sets err_q
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_q      <= 1'b0;
            permit_q     <= 1'b0;
            err_q        <= 1'b0;
            idle_stop_q  <= 1'b0;
            row_fmt_q    <= 1'b0;
            underrun_q   <= 1'b0;
            op_q         <= 4'h0;
            key_q        <= 2'h0;
            step_q       <= 16'h0000;
            flash_addr_o <= 24'h000000;
            flash_step_o <= 1'b0;
        end else begin
            flash_step_o <= advance;
            if (key_wr) begin
                if (reg_wdata_i[7:0] == `KEY_FIRST) begin
                    key_q <= 2'h1;
                end else if (reg_wdata_i[7:0] == `KEY_SECOND &&
                             key_q == 2'h1) begin
                    key_q <= 2'h2;
                end else begin
                    key_q <= 2'h0;
                end
            end else if (ctrl_wr || device_reset_o) begin
                key_q <= 2'h0;
            end
            if (ctrl_wr) begin
                permit_q    <= reg_wdata_i[`BIT_PERMIT];
                err_q       <= reg_wdata_i[`BIT_SEQ_ERR];
                idle_stop_q <= reg_wdata_i[`BIT_IDLE_STOP];
                row_fmt_q   <= reg_wdata_i[`BIT_ROW_FMT];
                underrun_q  <= reg_wdata_i[`BIT_ROW_UNDERRUN];
                if (!start_q) begin
                    op_q <= reg_wdata_i[`OP_MSB:`OP_LSB];
                end
            end
            if (start_ok) begin
                start_q      <= 1'b1;
                step_q       <= 16'h0000;
                flash_addr_o <= nvm_addr_i & `DW_ALIGN_MASK;
            end else if (advance) begin
                step_q <= step_q + 16'h1;
            end
            if (done) begin
                start_q <= 1'b0;
                err_q   <= 1'b0;
            end
            // Error sets are placed last so they win over any clear
            if (start_try && !start_ok) begin
                err_q <= 1'b1;
            end
            if (start_q && device_reset_o) begin
                start_q <= 1'b0;
                err_q   <= 1'b1;
            end
        end
    end

    assign reg_rdata_o = {start_q, permit_q, err_q, idle_stop_q,
                          2'b00, row_fmt_q, underrun_q,
                          4'h0, op_q};
    assign flash_op_o   = op_q;
    assign flash_busy_o = start_q;

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            power_save_grant_o <= 1'b0;
        end else begin
            power_save_grant_o <= power_save_req_i && !start_q;
        end
    end

endmodule

// >>> sim/flash_port_checker.sv
/* Concurrent checks on the serial flash program port's top-level ports.
   Assumes the default FLASH_LAST and one 100 MHz clock domain. */
`timescale 1ns/100ps

module flash_port_checker (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        prog_data_pin_oe_o,
    input wire logic        reg_wr_i,
    input wire logic        reg_sel_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic [23:0] pc_i,
    input wire logic        device_reset_o,
    input wire logic        idle_i,
    input wire logic        power_save_req_i,
    input wire logic        power_save_grant_o,
    input wire logic [23:0] flash_addr_o,
    input wire logic        flash_busy_o,
    input wire logic        flash_step_o
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Only writes while idle can start an operation
    wire ctl_wr = reg_wr_i && !reg_sel_i && !flash_busy_o;

    property p_busy_bit; flash_busy_o == reg_rdata_o[15]; endproperty
    a_busy_bit: assert property (p_busy_bit)
        else $error("busy flag differs from start bit");
    property p_gap_zero;
        reg_rdata_o[11:10] == 2'h0 && reg_rdata_o[7:4] == 4'h0;
    endproperty
    a_gap_zero: assert property (p_gap_zero)
        else $error("unimplemented bits read nonzero");
    property p_permit; ctl_wr && !reg_wdata_i[14] |=> !flash_busy_o; endproperty
    a_permit: assert property (p_permit)
        else $error("operation started without permit");
    property p_bad_op;
        ctl_wr && reg_wdata_i[15] && !(reg_wdata_i[3:0] inside {4'hE, 4'h3,
        4'h1}) |=> !flash_busy_o && reg_rdata_o[13];
    endproperty
    a_bad_op: assert property (p_bad_op)
        else $error("unimplemented operation accepted");
    property p_psave;
        power_save_req_i && flash_busy_o ##1 flash_busy_o
        |-> !power_save_grant_o;
    endproperty
    a_psave: assert property (p_psave)
        else $error("power save granted while busy");
    property p_clear_cause;
        $fell(flash_busy_o) |-> flash_step_o || $past(flash_step_o)
        || device_reset_o || $past(device_reset_o);
    endproperty
    a_clear_cause: assert property (p_clear_cause)
        else $error("start bit cleared without completion");
    property p_idle_pause;
        idle_i && reg_rdata_o[12] ##1 idle_i && reg_rdata_o[12]
        |-> !flash_step_o;
    endproperty
    a_idle_pause: assert property (p_idle_pause)
        else $error("operation stepped in idle with idle stop");
    property p_align; flash_busy_o |-> flash_addr_o[2:0] == 3'h0; endproperty
    a_align: assert property (p_align)
        else $error("flash address not aligned");
    property p_pc_reset; pc_i <= 24'h0001FF |=> device_reset_o; endproperty
    a_pc_reset: assert property (p_pc_reset)
        else $error("no device reset for vector address");
    property p_oe_hold; $rose(prog_data_pin_oe_o) |-> prog_data_pin_oe_o[*8];
    endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("data pin output dropped early");
endmodule

bind serial_flash_program_port flash_port_checker chk (.*);

// >>> sim/flash_programmer_model.sv
/* Programmer model: drives the programming clock and data pins.
   Assumes the 100 MHz system clock for pacing and a pulled-up data pin. */
`timescale 1ns/100ps

module flash_programmer_model (
    input  wire logic clock_i,
    input  wire logic pin_i,
    output logic      pclk_o,
    output logic      pdat_o,
    output logic      pdat_oe_o
);
    // ------------------------------------------------------------
    // Bit timing: 160 ns period, clock stands low between frames
    // ------------------------------------------------------------
    initial begin
        pclk_o = 1'b0;
        pdat_o = 1'b0;
        pdat_oe_o = 1'b0;
    end

    task automatic half();
        repeat (8) @(negedge clock_i);
    endtask

    task automatic send(input int n, input logic [23:0] val);
        for (int i = 0; i < n; i++) begin
            pclk_o = 1'b0;
            pdat_oe_o = 1'b1;
            pdat_o = val[i];
            half();
            pclk_o = 1'b1;
            half();
        end
        pclk_o = 1'b0;
    endtask

    task automatic serial_instruction_execute(input logic [23:0] instr);
        send(4, 24'h000000);
        send(24, instr);
    endtask

    task automatic register_readout_code(output logic [15:0] val);
        send(4, 24'h000001);
        pdat_oe_o = 1'b0;
        for (int i = 0; i < 24; i++) begin
            pclk_o = 1'b0;
            half();
            pclk_o = 1'b1;
            if (i > 7) val[i-8] = pin_i;
            half();
        end
        pclk_o = 1'b0;
    endtask
endmodule

// >>> sim/test_serial_flash_program_port.sv
/* Self-checking bench for the serial flash program port.
   Assumes the programmer model and the bound checker are compiled. */
`timescale 1ns/100ps

module test_serial_flash_program_port;
    logic        clock_i = 1'b0, rst_n_i = 1'b0, instr_ready_i = 1'b1;
    logic        reg_wr_i = 1'b0, reg_sel_i = 1'b0, idle_i = 1'b0;
    logic        power_save_req_i = 1'b0;
    logic [15:0] reg_wdata_i = 16'h0000, visi_data_i = 16'hC35A, v;
    logic [23:0] pc_i = 24'h000200, nvm_addr_i = 24'h000A47;
    wire         prog_clock_pin_i, prog_data_pin_i, pm_d, pm_oe;
    wire         prog_data_pin_o, prog_data_pin_oe_o, instr_valid_o;
    wire         cpu_tick_o, device_reset_o, power_save_grant_o;
    wire         flash_busy_o, flash_step_o;
    wire  [15:0] reg_rdata_o;
    wire  [23:0] instr_data_o, flash_addr_o;
    wire  [3:0]  flash_op_o;
    logic [23:0] got[$];
    logic [3:0]  ops[3] = '{4'hE, 4'h3, 4'h1};
    logic [23:0] bad_pc[2] = '{24'h0001FF, 24'h02ABFF};
    int          bad_count = 0, check_count = 0;
    int          ticks = 0, n_tick = 0;

    // Programmer wins while it drives: the device's hold ends at that rise
    assign prog_data_pin_i = pm_oe ? pm_d
                           : (prog_data_pin_oe_o ? prog_data_pin_o : 1'b1);

    serial_flash_program_port dut (.*);
    flash_programmer_model pm (
        .clock_i   (clock_i),
        .pin_i     (prog_data_pin_i),
        .pclk_o    (prog_clock_pin_i),
        .pdat_o    (pm_d),
        .pdat_oe_o (pm_oe)
    );

    always #5 clock_i = ~clock_i;

    // CPU side pops every instruction so no serial edges are lost
    always @(posedge clock_i) begin
        if (instr_valid_o)
            got.push_back(instr_data_o);
        if (cpu_tick_o)
            ticks++;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [23:0] a, input logic [23:0] e);
        check_count++;
        if (a !== e) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, a, e);
        end
    endtask

    task automatic wr(input logic s, input logic [15:0] d);
        @(negedge clock_i);
        reg_sel_i = s;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clock_i);
        reg_wr_i = 1'b0;
    endtask

    task automatic key();
        wr(1'b1, 16'h0055);
        wr(1'b1, 16'h00AA);
    endtask

    task automatic pulse(input logic e);
        @(negedge clock_i);
        power_save_req_i = 1'b1;
        @(negedge clock_i);
        power_save_req_i = 1'b0;
        chk(power_save_grant_o, e);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        bad_count++;
        $display("mismatch at %0t: run timed out", $time);
        summarize();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clock_i);
        chk(reg_rdata_o, 16'h0000);
        pm.serial_instruction_execute(24'h040200);
        for (int c = 2; c < 16; c++) begin
            pm.send(4, c);
        end
        pm.serial_instruction_execute(24'h000000);
        repeat (12) @(negedge clock_i);
        chk(got.size(), 2);
        chk(got[0], 24'h040200);
        chk(got[1], 24'h000000);
        n_tick = ticks;
        pm.register_readout_code(v);
        chk(ticks - n_tick, 4);
        chk(v, 16'hC35A);
        repeat (12) @(negedge clock_i);
        chk(prog_data_pin_oe_o, 1'b1);
        wr(1'b0, 16'h0CF0);
        chk(reg_rdata_o & 16'h0CF0, 16'h0000);
        wr(1'b0, 16'hC00E);
        chk(reg_rdata_o, 16'h600E);
        key();
        wr(1'b0, 16'h800E);
        chk(reg_rdata_o, 16'h200E);
        key();
        wr(1'b0, 16'hC002);
        chk(reg_rdata_o, 16'h6002);
        foreach (ops[k]) begin
            wr(1'b0, {12'h500, ops[k]});
            key();
            wr(1'b0, {12'hD00, ops[k]});
            chk(reg_rdata_o & 16'hD00F, {12'hD00, ops[k]});
            chk(flash_op_o, ops[k]);
            chk(flash_addr_o, 24'h000A40);
            wr(1'b0, {12'h500, ops[k]});
            chk(flash_busy_o, 1'b1);
            pulse(1'b0);
            idle_i = 1'b1;
            pm.serial_instruction_execute(24'h000000);
            chk(flash_busy_o, 1'b1);
            idle_i = 1'b0;
            v = 16'h8000;
            for (int n = 0; n < 20 && v[15]; n++) begin
                visi_data_i = reg_rdata_o;
                pm.register_readout_code(v);
            end
            chk(v, {12'h500, ops[k]});
            if (v[15])
                summarize();
        end
        pulse(1'b1);
        // A device reset cuts a running operation short
        wr(1'b0, 16'h5001);
        key();
        wr(1'b0, 16'hD001);
        pc_i = 24'h0001FF;
        repeat (3) @(negedge clock_i);
        chk(reg_rdata_o, 16'h7001);
        foreach (bad_pc[k]) begin
            pc_i = bad_pc[k];
            repeat (2) @(negedge clock_i);
            chk(device_reset_o, 1'b1);
        end
        pc_i = 24'h000200;
        repeat (2) @(negedge clock_i);
        chk(device_reset_o, 1'b0);
        summarize();
    end
endmodule
